// ==== mdl_conv_model.sv ====
/*
 Behavioural model of the converter on the far side of the deskew receiver.
 Assumes it shares the frame clock with the receiver; lane i starts SKEW*i frames late.
*/
module mdl_conv_model
   import mdl_pkg::*;
#(
   parameter int SKEW = 1,
   parameter logic [LFSR_W-1:0] SEED = 17'h0B5A3 // Arbitrary nonzero start
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic trigger,
   input wire logic pause,
   output logic [NUM_LANES*FRAME_W-1:0] frames,
   output logic [NUM_LANES-1:0] valid
);
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // Scrambler
   // -----------------------------------------------------------------
   int t;
   logic started;
   logic [LFSR_W-1:0] lfsr [NUM_LANES];

   function automatic logic [LFSR_W-1:0] step14(input logic [LFSR_W-1:0] s);
      logic [LFSR_W-1:0] n;
      for (int k = 0; k < LFSR_W; k++)
      begin
         n[k] = (k < 3) ? s[k+14] : (s[k-3] ^ s[k]);
      end
      return n;
   endfunction : step14

   // -----------------------------------------------------------------
   // Lane frames
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      int f;
      logic [14:0] w;
      if (!rst_b)
      begin
         t <= 0;
         started <= 1'b0;
         frames <= '0;
         valid <= '0;
      end
      else if (trigger)
      begin
         t <= 0;
         started <= 1'b1;
         valid <= '0;
         frames <= ~frames;
         for (int i = 0; i < NUM_LANES; i++)
            lfsr[i] <= SEED + LFSR_W'(i);
      end
      else if (!started || pause)
      begin
         // Idle lanes toggle so a stale word never looks valid
         valid <= '0;
         frames <= ~frames;
      end
      else
      begin
         t <= t + 1;
         for (int i = 0; i < NUM_LANES; i++)
         begin
            f = t - SKEW * i;
            valid[i] <= (f >= 0);
            if (f < 0)
               frames[16*i+:16] <= ~frames[16*i+:16];
            else if (f < 32)
               frames[16*i+:16] <= f[0] ? ALIGN_WORD_LO : ALIGN_WORD_HI;
            else
            begin
               w = {f[0], (f < 64) ? lfsr[i][13:0] : ({2'(i), 12'(f - 64)} ^ lfsr[i][13:0])};
               frames[16*i+:16] <= f[0] ? {1'b1, ~w} : {1'b0, w};
               lfsr[i] <= step14(lfsr[i]);
            end
         end
      end
   end
endmodule : mdl_conv_model

// ==== mdl_deskew.sv ====
/*
 Multilane deskew receiver with deterministic-latency release.
 Assumes lane frames, the sync pulse it sends and the read port all run on the
 frame clock clk, synchronous with the converter master clock.
*/
// How it works
// - Each lane writes decoded data once the comma-to-PRBS change is seen.
// - Reading starts only after every lane has aligned, all lanes together.
// - Deskew buffer per lane is a FIFO; single clock here.
// - Frames align on either comma word, then the descrambler seeds and decodes.
// - Non-deterministic mode releases once every lane FIFO holds a word or every lane has aligned.
// - Sync pulse starts the counter and rearms every lane.
// - Deterministic mode holds data until the counter hits its end value.
// - Training captures the count when all FIFOs first hold a word.
// - End value is captured count plus margin, loaded before normal mode.
// - Counter, read port and sync generation share the frame clock.
// - Without the counter, release on all FIFOs filled or all lanes aligned.
module mdl_deskew
   import mdl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic sync_req,
   input wire logic det_mode,
   input wire logic train_mode,
   input wire logic [CNT_W-1:0] end_value,
   input wire logic [NUM_LANES*FRAME_W-1:0] lane_frames,
   input wire logic [NUM_LANES-1:0] lane_valid,
   input wire logic out_ready,
   output logic converter_trigger_input,
   output logic lanes_ready,
   output logic released,
   output logic [CNT_W-1:0] captured_count,
   output logic captured,
   output logic [NUM_LANES-1:0] fifo_space,
   output logic out_valid,
   output logic [OUT_W-1:0] out_data
);
   logic [NUM_LANES-1:0] found, dec_valid, f_in_ready, f_valid;
   logic [DATA_W-1:0] dec_data [NUM_LANES];
   logic [DATA_W-1:0] f_data [NUM_LANES];
   logic [OUT_W-1:0] f_cat;
   logic sync_fire, all_have, rd_all, take;
   logic req_d, next_req_d;
   logic running, next_running;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic next_trig, next_lanes_ready, next_released, next_captured;
   logic [CNT_W-1:0] next_captured_count;
   logic [NUM_LANES-1:0] next_fifo_space;
   logic next_out_valid;
   logic [OUT_W-1:0] next_out_data;

   // -----------------------------------------------------------------
   // Lanes and deskew FIFOs
   // -----------------------------------------------------------------
   for (genvar i = 0; i < NUM_LANES; i++)
   begin : g_lane
      mdl_lane u_lane (
         .clk(clk),
         .rst_b(rst_b),
         .ce(ce),
         .rearm(sync_fire),
         .frame_in(lane_frames[i*FRAME_W +: FRAME_W]),
         .frame_valid(lane_valid[i]),
         .found(found[i]),
         .dec_data(dec_data[i]),
         .dec_valid(dec_valid[i])
      );

      // Decoded words land here; a full FIFO drops words and shows in fifo_space
      mdl_fifo #(
         .WIDTH(DATA_W),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .clk(clk),
         .rst_b(rst_b),
         .ce(ce),
         .flush(sync_fire),
         .in_valid(dec_valid[i]),
         .in_ready(f_in_ready[i]),
         .in_data(dec_data[i]),
         .out_valid(f_valid[i]),
         .out_ready(rd_all),
         .out_data(f_data[i])
      );

      assign f_cat[i*DATA_W +: DATA_W] = f_data[i];
   end

   // -----------------------------------------------------------------
   // Sync, counter, release and output stage
   // -----------------------------------------------------------------
   always_comb
   begin
      sync_fire = sync_req && !req_d && ce;
      all_have = &f_valid;
      take = !out_valid || out_ready;
      // Every lane pops in the same cycle so alignment is kept
      rd_all = released && lanes_ready && all_have && take && ce && !sync_fire;
      next_req_d = sync_req;
      next_trig = sync_fire;
      next_running = running;
      next_cnt = cnt;
      next_released = released;
      next_captured = captured;
      next_captured_count = captured_count;
      next_lanes_ready = &found && !sync_fire;
      next_fifo_space = f_in_ready;
      next_out_valid = out_valid;
      next_out_data = out_data;
      if (sync_fire)
      begin
         next_running = 1'b1;
         next_cnt = CNT_ZERO;
         next_released = 1'b0;
         next_captured = 1'b0;
         next_out_valid = 1'b0;
      end
      else
      begin
         if (running && ce)
            next_cnt = cnt + CNT_ONE;
         if (train_mode && running && !captured && all_have)
         begin
            next_captured = 1'b1;
            next_captured_count = cnt;
         end
         if (det_mode)
         begin
            // End value comes from training plus a margin set by software
            if (running && cnt == end_value)
               next_released = 1'b1;
         end
         else if (all_have || lanes_ready)
            next_released = 1'b1;
         if (rd_all)
         begin
            next_out_valid = 1'b1;
            next_out_data = f_cat;
         end
         else if (out_ready)
            next_out_valid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         req_d <= 1'b0;
         converter_trigger_input <= 1'b0;
         running <= 1'b0;
         cnt <= CNT_ZERO;
         released <= 1'b0;
         captured <= 1'b0;
         captured_count <= CNT_ZERO;
         lanes_ready <= 1'b0;
         fifo_space <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else if (ce)
      begin
         req_d <= next_req_d;
         converter_trigger_input <= next_trig;
         running <= next_running;
         cnt <= next_cnt;
         released <= next_released;
         captured <= next_captured;
         captured_count <= next_captured_count;
         lanes_ready <= next_lanes_ready;
         fifo_space <= next_fifo_space;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   AST_TRIG_ONE_CYCLE: assert property (converter_trigger_input && ce |=> !converter_trigger_input)
      else $error("trigger longer than one cycle");
   AST_READY_CLEARED: assert property (converter_trigger_input |-> !lanes_ready)
      else $error("lanes ready survived sync");
   AST_READY_AND: assert property (ce && !(&found) |=> !lanes_ready)
      else $error("lanes ready without all lanes");
   AST_CNT_RUN: assert property (running && ce && !sync_fire |=> cnt == $past(cnt) + CNT_ONE)
      else $error("counter did not advance");
   AST_CNT_START: assert property (sync_fire |=> running && cnt == CNT_ZERO)
      else $error("counter not restarted by sync");
   AST_DET_RELEASE: assert property (det_mode && running && ce && !sync_fire
      && cnt == end_value |=> released)
      else $error("no release at end value");
   AST_NONDET_RELEASE: assert property (!det_mode && ce && !sync_fire && all_have |=> released)
      else $error("no release with all lanes filled");
   AST_HOLD: assert property (ce && $rose(out_valid) |-> $past(released) && $past(lanes_ready))
      else $error("data out before release");
   AST_TRAIN: assert property (train_mode && running && !captured && all_have && ce
      && !sync_fire |=> captured && captured_count == $past(cnt))
      else $error("training count not captured");
   AST_LANE_REARM: assert property (sync_fire |=> found == '0)
      else $error("lane not rearmed by sync");

   // -----------------------------------------------------------------
   // Sync and counter checks
   // -----------------------------------------------------------------

   AST_TRIG_NEEDS_REQ: assert property ($rose(converter_trigger_input)
      |-> $past(sync_req) && !$past(req_d))
      else $error("trigger without request edge");

   AST_SYNC_CLR_RELEASE: assert property (sync_fire |=> !released)
      else $error("release survived sync");

   AST_SYNC_CLR_CAPTURE: assert property (sync_fire |=> !captured)
      else $error("capture survived sync");

   AST_SYNC_CLR_OUT: assert property (sync_fire |=> !out_valid)
      else $error("output survived sync");

   AST_FLUSH: assert property (sync_fire |=> f_valid == '0)
      else $error("buffers not flushed by sync");

   AST_RUN_STAY: assert property (running && ce |=> running)
      else $error("counter stopped");

   AST_IDLE_CNT: assert property (!running && ce && !sync_fire |=> cnt == $past(cnt))
      else $error("counter moved before sync");

   AST_READY_SET: assert property (ce && !sync_fire && (&found) |=> lanes_ready)
      else $error("lanes ready missing");

   // -----------------------------------------------------------------
   // Release and output checks
   // -----------------------------------------------------------------

   AST_RD_GATE: assert property (rd_all |-> all_have && released && lanes_ready)
      else $error("read before alignment");

   AST_RD_TAKE: assert property (rd_all |-> !out_valid || out_ready)
      else $error("read over a stalled word");

   AST_OUT_DATA: assert property (rd_all |=> out_valid && out_data == $past(f_cat))
      else $error("output word not the popped word");

   AST_OUT_STALL: assert property (out_valid && !out_ready && ce && !sync_fire
      |=> out_valid && $stable(out_data))
      else $error("stalled word changed");

   AST_OUT_DROP: assert property (out_valid && out_ready && ce && !rd_all && !sync_fire
      |=> !out_valid)
      else $error("taken word repeated");

   AST_RELEASE_HOLD: assert property (released && ce && !sync_fire |=> released)
      else $error("release dropped without sync");

   AST_DET_NO_EARLY: assert property (det_mode && !released && ce
      && !(running && cnt == end_value) |=> !released)
      else $error("early deterministic release");

   AST_DET_CAUSE: assert property ($rose(released) && $past(det_mode)
      |-> $past(cnt) == $past(end_value))
      else $error("release away from end value");

   AST_NONDET_CAUSE: assert property ($rose(released) && !$past(det_mode)
      |-> $past(all_have) || $past(lanes_ready))
      else $error("release without filled buffers");

   AST_NONDET_READY_RELEASE: assert property (!det_mode && ce && !sync_fire
      && lanes_ready |=> released)
      else $error("no release with lanes ready");

   AST_CAPTURE_HOLD: assert property (captured && ce && !sync_fire
      |=> captured && $stable(captured_count))
      else $error("captured count moved");

   AST_NO_CAPTURE_OFF: assert property (!train_mode && !captured && ce |=> !captured)
      else $error("capture outside training");

   AST_CAPTURE_CAUSE: assert property ($rose(captured)
      |-> $past(train_mode) && $past(all_have))
      else $error("capture without filled buffers");

   AST_FIFO_SPACE: assert property (ce |=> fifo_space == $past(f_in_ready))
      else $error("buffer space flag wrong");

   AST_FROZEN: assert property (!ce |=> $stable(cnt) && $stable(released)
      && $stable(out_valid) && $stable(out_data))
      else $error("state moved with clock enable low");

   for (genvar i = 0; i < NUM_LANES; i++)
   begin : g_chk
      AST_LANE_WRITE: assert property (dec_valid[i] |-> found[i])
         else $error("lane wrote before alignment");
   end

   COV_FILL: cover property (fifo_space == '0);
   COV_RESYNC: cover property (released ##1 sync_fire);
   COV_DET: cover property (det_mode && !released ##1 released);
   COV_TRAIN: cover property (train_mode && $rose(captured));
   COV_OUT: cover property (lanes_ready && $rose(out_valid));
endmodule : mdl_deskew

// ==== mdl_fifo.sv ====
/*
 Synchronous deskew FIFO with valid/ready on both sides.
 Assumes writer and reader share clk; ce freezes all state.
*/
module mdl_fifo
   import mdl_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [AW:0] count, next_count;
   logic wr, rd;

   assign in_ready = (count != DEPTH_C);
   assign out_valid = (count != '0);
   assign out_data = mem[rptr];

   // -----------------------------------------------------------------
   // Pointer update
   // -----------------------------------------------------------------
   always_comb
   begin
      wr = in_valid && in_ready && ce;
      rd = out_valid && out_ready && ce;
      next_wptr = wr ? ((wptr == LAST) ? '0 : wptr + 1'b1) : wptr;
      next_rptr = rd ? ((rptr == LAST) ? '0 : rptr + 1'b1) : rptr;
      next_count = count;
      if (wr && !rd)
         next_count = count + 1'b1;
      else if (rd && !wr)
         next_count = count - 1'b1;
      // Flush wins over any push or pop so no stale word outlives a resync
      if (flush && ce)
      begin
         next_wptr = '0;
         next_rptr = '0;
         next_count = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end
      else
      begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
      end
   end

   // Storage carries no reset; only the pointers qualify it
   always_ff @(posedge clk)
   begin
      if (wr)
         mem[wptr] <= in_data;
   end
endmodule : mdl_fifo

// ==== mdl_lane.sv ====
/*
 One lane: frame alignment, PRBS seeding, disparity undo and descrambling.
 Assumes lane frames arrive word-aligned on clk; rearm comes with each sync pulse.
*/
module mdl_lane
   import mdl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic rearm,
   input wire logic [FRAME_W-1:0] frame_in,
   input wire logic frame_valid,
   output logic found,
   output logic [DATA_W-1:0] dec_data,
   output logic dec_valid
);
   mdl_lane_state_e state, next_state;
   logic [FRAME_W-1:0] prev, next_prev;
   logic [LFSR_W-1:0] lfsr, next_lfsr;
   logic [DATA_W-1:0] first, next_first;
   logic [DATA_W-1:0] next_dec_data;
   logic next_found, next_dec_valid;
   logic [FRAME_W-1:0] undone;
   logic is_align, comma;
   logic [LFSR_W-1:0] seed;

   // -----------------------------------------------------------------
   // Alignment and decode
   // -----------------------------------------------------------------
   always_comb
   begin
      undone = frame_in;
      if (frame_in[DISP_BIT])
         undone[DISP_BIT-1:0] = ~frame_in[DISP_BIT-1:0];
      is_align = (frame_in == ALIGN_WORD_HI) || (frame_in == ALIGN_WORD_LO);
      comma = ({prev, frame_in} == COMMA_A) || ({prev, frame_in} == COMMA_B);
      seed = {undone[2:0], first};
      next_state = state;
      next_prev = prev;
      next_lfsr = lfsr;
      next_first = first;
      next_found = found;
      next_dec_data = dec_data;
      next_dec_valid = 1'b0;
      if (rearm)
      begin
         next_state = MDL_HUNT;
         next_found = 1'b0;
      end
      else if (frame_valid)
      begin
         next_prev = frame_in;
         case (state)
            MDL_HUNT:
               if (comma)
                  next_state = MDL_ALIGN;
            MDL_ALIGN:
               if (!is_align)
               begin
                  // First PRBS frame after the comma run
                  next_first = undone[DATA_W-1:0];
                  next_state = MDL_PRBS2;
               end
            MDL_PRBS2:
            begin
               // Second frame fixes the top three seed bits
               next_lfsr = mdl_lfsr_step(mdl_lfsr_step(seed));
               next_found = 1'b1;
               next_state = MDL_RUN;
            end
            MDL_RUN:
            begin
               next_dec_data = undone[DATA_W-1:0] ^ lfsr[DATA_W-1:0];
               next_dec_valid = 1'b1;
               next_lfsr = mdl_lfsr_step(lfsr);
            end
            default:
               next_state = MDL_HUNT;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= MDL_HUNT;
         prev <= '0;
         lfsr <= '0;
         first <= '0;
         found <= 1'b0;
         dec_data <= '0;
         dec_valid <= 1'b0;
      end
      else if (ce)
      begin
         state <= next_state;
         prev <= next_prev;
         lfsr <= next_lfsr;
         first <= next_first;
         found <= next_found;
         dec_data <= next_dec_data;
         dec_valid <= next_dec_valid;
      end
   end
endmodule : mdl_lane

// ==== mdl_pkg.sv ====
/*
 Shared constants, types and helpers for the multilane deskew receiver.
 Assumes every lane frame, the sync pulse and the read port share one frame clock.
*/
package mdl_pkg;
   // -----------------------------------------------------------------
   // Link geometry
   // -----------------------------------------------------------------
   localparam int NUM_LANES = 4;
   localparam int FRAME_W = 16;
   localparam int DATA_W = 14;
   localparam int LFSR_W = 17;
   localparam int FIFO_DEPTH = 8;
   localparam int CNT_W = 16;
   localparam int DISP_BIT = 15;
   localparam int FIFO_AW = $clog2(FIFO_DEPTH);
   localparam int OUT_W = NUM_LANES * DATA_W;

   // -----------------------------------------------------------------
   // Alignment words
   // -----------------------------------------------------------------
   localparam logic [FRAME_W-1:0] ALIGN_WORD_HI = 16'hFF00;
   localparam logic [FRAME_W-1:0] ALIGN_WORD_LO = 16'h00FF;
   localparam logic [2*FRAME_W-1:0] COMMA_A = 32'hFF0000FF;
   localparam logic [2*FRAME_W-1:0] COMMA_B = 32'h00FFFF00;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   // -----------------------------------------------------------------
   // Lane alignment states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MDL_HUNT = 2'b00,
      MDL_ALIGN = 2'b01,
      MDL_PRBS2 = 2'b10,
      MDL_RUN = 2'b11
   } mdl_lane_state_e;

   // One 14-bit step of the x^17 + x^3 + 1 generator
   function automatic logic [LFSR_W-1:0] mdl_lfsr_step(input logic [LFSR_W-1:0] s);
      logic [LFSR_W-1:0] n;
      n = '0;
      for (int k = 0; k < LFSR_W; k++)
      begin
         if (k < 3)
            n[k] = s[k+DATA_W];
         else
            n[k] = s[k-3] ^ s[k];
      end
      return n;
   endfunction : mdl_lfsr_step
endpackage : mdl_pkg

// ==== tb.sv ====
/*
 Self-checking bench for the multilane deskew receiver.
 Assumes a sync pulse flushes and rearms every lane buffer.
*/
module tb
   import mdl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst_b, ce, sync_req, det_mode, train_mode, out_ready, pause;
   logic [CNT_W-1:0] end_value, captured_count, since_trig, cap;
   logic [NUM_LANES*FRAME_W-1:0] lane_frames;
   logic [NUM_LANES-1:0] lane_valid, fifo_space;
   logic converter_trigger_input, lanes_ready, released, captured, out_valid;
   logic [OUT_W-1:0] out_data;
   int bad_count, check_count;

   mdl_deskew mdl_deskew_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .sync_req(sync_req),
      .det_mode(det_mode), .train_mode(train_mode), .end_value(end_value),
      .lane_frames(lane_frames), .lane_valid(lane_valid), .out_ready(out_ready),
      .converter_trigger_input(converter_trigger_input), .lanes_ready(lanes_ready),
      .released(released), .captured_count(captured_count), .captured(captured),
      .fifo_space(fifo_space), .out_valid(out_valid), .out_data(out_data));

   mdl_conv_model mdl_conv_model_inst (.clk(clk), .rst_b(rst_b),
      .trigger(converter_trigger_input), .pause(pause), .frames(lane_frames),
      .valid(lane_valid));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Cycles since the trigger pulse; tracks the receiver counter
   always @(posedge clk)
      since_trig <= converter_trigger_input ? CNT_ONE : since_trig + CNT_ONE;

   task results;
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   task chk(input bit ok, input string m);
      check_count++;
      if (!ok)
      begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk

   task lost(input string m);
      chk(1'b0, m);
      results();
   endtask : lost

   function automatic logic [OUT_W-1:0] exp_word(input int k);
      logic [OUT_W-1:0] r;
      for (int i = 0; i < NUM_LANES; i++)
         r[14*i+:14] = (k < 30) ? 14'h0000 : {2'(i), 12'(k - 30)};
      return r;
   endfunction : exp_word

   task do_sync;
      int pulses;
      pulses = 0;
      @(posedge clk);
      sync_req <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk(converter_trigger_input === 1'b1, "no trigger");
      chk(lanes_ready === 1'b0 && released === 1'b0 && captured === 1'b0, "flags kept");
      repeat (3)
      begin
         @(negedge clk);
         if (converter_trigger_input !== 1'b0)
            pulses++;
      end
      chk(pulses == 0, "held request fired twice");
      @(posedge clk);
      sync_req <= 1'b0;
   endtask : do_sync

   task collect(input int n);
      int j;
      for (int k = 0; k < n; k++)
      begin
         for (j = 0; j < 100 && out_valid !== 1'b1; j++)
            @(negedge clk);
         if (j == 100)
            lost("no output word");
         chk(out_data === exp_word(k), "lane data");
         @(negedge clk);
      end
   endtask : collect

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task test_stream;
      @(posedge clk);
      det_mode <= 1'b0;
      out_ready <= 1'b1;
      do_sync();
      collect(40);
      chk(lanes_ready === 1'b1 && released === 1'b1, "flags after align");
   endtask : test_stream

   task test_train;
      int j;
      @(posedge clk);
      det_mode <= 1'b1;
      train_mode <= 1'b1;
      end_value <= 16'hFFFF;
      do_sync();
      for (j = 0; j < 300 && captured !== 1'b1; j++)
         @(negedge clk);
      if (j == 300)
         lost("no capture");
      chk(captured_count === since_trig - CNT_ONE, "captured count");
      chk(released === 1'b0 && out_valid === 1'b0, "data not held");
      cap = captured_count;
   endtask : test_train

   task test_det;
      int j;
      @(posedge clk);
      train_mode <= 1'b0;
      end_value <= cap + 16'h0001;
      do_sync();
      for (j = 0; j < 300 && released !== 1'b1; j++)
      begin
         chk(out_valid === 1'b0, "early output");
         @(negedge clk);
      end
      if (j == 300)
         lost("no release");
      chk(since_trig === end_value + CNT_ONE, "release time");
      collect(40);
   endtask : test_det

   task test_fill;
      int j, n;
      logic [OUT_W-1:0] d;
      @(posedge clk);
      det_mode <= 1'b0;
      out_ready <= 1'b0;
      do_sync();
      for (j = 0; j < 300 && fifo_space !== 4'h0; j++)
         @(negedge clk);
      if (j == 300)
         lost("buffers never full");
      @(posedge clk);
      pause <= 1'b1;
      d = out_data;
      repeat (5) @(negedge clk);
      chk(out_valid === 1'b1 && out_data === d, "stalled word moved");
      @(posedge clk);
      out_ready <= 1'b1;
      n = 0;
      repeat (20)
      begin
         @(negedge clk);
         if (out_valid === 1'b1)
         begin
            chk(out_data === exp_word(n), "drained data");
            n++;
         end
      end
      chk(n == 9 && fifo_space === 4'hF, "drain count");
      @(posedge clk);
      pause <= 1'b0;
   endtask : test_fill

   initial
   begin
      rst_b = 1'b0;
      ce = 1'b1;
      sync_req = 1'b0;
      det_mode = 1'b0;
      train_mode = 1'b0;
      end_value = 16'h0000;
      out_ready = 1'b0;
      pause = 1'b0;
      bad_count = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      test_stream();
      test_train();
      test_det();
      test_fill();
      results();
   end
endmodule : tb
